// ---- rtl/dbra_regs.svh ----
`ifndef DBRA_REGS_SVH
`define DBRA_REGS_SVH

// register byte offsets on the axi4-lite slave
`define DBRA_OFF_CAPABILITY  8'h00
`define DBRA_OFF_CTRL        8'h04
`define DBRA_OFF_BANK_STATE  8'h08
`define DBRA_OFF_VIOLATION   8'h0c
`define DBRA_OFF_ACT_TOTAL   8'h10

// capability code: unlimited activations, upper nibble reads zero
`define DBRA_CAP_RESET       8'h08
`define DBRA_CAP_CODE_W      4

// control register fields and reset
`define DBRA_CTRL_TNR_EN_BIT 0
`define DBRA_CTRL_THR_LSB    16
`define DBRA_CTRL_RESET      32'h0400_0001

// violation register bit positions
`define DBRA_VIO_ACT_BUSY    0
`define DBRA_VIO_ACC_IDLE    1
`define DBRA_VIO_RRD_S       2
`define DBRA_VIO_RRD_L       3
`define DBRA_VIO_FAW         4
`define DBRA_VIO_W           5

// geometry
`define DBRA_ROW_W           18
`define DBRA_CNT_W           8

// clock and timing (clock period in ps, write data in cycles, other times in ns)
`define DBRA_CLK_PS          5000
`define DBRA_T_RP_NS         15
`define DBRA_T_RAS_NS        35
`define DBRA_T_RTP_NS        8
`define DBRA_T_WR_NS         15
`define DBRA_T_RRD_S_NS      5
`define DBRA_T_RRD_L_NS      8
`define DBRA_T_FAW_NS        30
`define DBRA_WR_DATA_CYC     16
// least times round up to whole cycles
`define DBRA_NS2CYC(ns) ((((ns) * 1000) + `DBRA_CLK_PS - 1) / `DBRA_CLK_PS)

`endif

// ---- rtl/dbra_pkg.sv ----
package dbra_pkg;
   // per-bank row state
   typedef enum logic [1:0] {
      DBRA_IDLE,
      DBRA_ACTIVE,
      DBRA_AP_WAIT,
      DBRA_PRECHARGING
   } dbra_bank_state_t;

   // decoded command on the command pins
   typedef enum logic [2:0] {
      DBRA_CMD_NOP,
      DBRA_CMD_ACT,
      DBRA_CMD_PRE,
      DBRA_CMD_RD,
      DBRA_CMD_WR
   } dbra_cmd_t;

   // bank tracker state
   typedef struct packed {
      dbra_bank_state_t state;
      logic [17:0]      row;
      logic [7:0]       ras_cnt;
      logic [7:0]       lock_cnt;
      logic [7:0]       rp_cnt;
      logic             err_act;
      logic             err_acc;
   } dbra_bank_t;
endpackage : dbra_pkg

// ---- rtl/dbra_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbra_regs.svh"

module dbra_bank (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      act,       // activate this bank
   input  wire logic                      pre,       // precharge this bank
   input  wire logic                      rd,        // read to this bank
   input  wire logic                      wr,        // write to this bank
   input  wire logic                      ap,        // auto precharge with rd/wr
   input  wire logic [`DBRA_ROW_W-1:0]    row_in,    // row on activate
   output var  dbra_pkg::dbra_bank_state_t state,    // current bank state
   output var  logic [`DBRA_ROW_W-1:0]    open_row,  // row held open
   output var  logic                      err_act,   // activate while not idle
   output var  logic                      err_acc    // access while not open
);
   localparam logic [7:0] T_RP  = 8'(`DBRA_NS2CYC(`DBRA_T_RP_NS));
   localparam logic [7:0] T_RAS = 8'(`DBRA_NS2CYC(`DBRA_T_RAS_NS));
   localparam logic [7:0] T_RTP = 8'(`DBRA_NS2CYC(`DBRA_T_RTP_NS));
   // write restore: data burst lands, then write recovery
   localparam logic [7:0] T_WRA = 8'(`DBRA_WR_DATA_CYC + `DBRA_NS2CYC(`DBRA_T_WR_NS));

   dbra_pkg::dbra_bank_t r;       // registered state
   dbra_pkg::dbra_bank_t next_r;  // next state

   // bank state machine
   always_comb begin
      next_r         = r;
      next_r.err_act = 1'b0;
      next_r.err_acc = 1'b0;
      // free-running countdowns stop at zero
      if (r.ras_cnt != 8'h00) next_r.ras_cnt = r.ras_cnt - 8'h01;
      if (r.lock_cnt != 8'h00) next_r.lock_cnt = r.lock_cnt - 8'h01;
      if (r.rp_cnt != 8'h00) next_r.rp_cnt = r.rp_cnt - 8'h01;
      unique case (r.state)
         dbra_pkg::DBRA_IDLE: begin
            if (act) begin
               next_r.state   = dbra_pkg::DBRA_ACTIVE;
               next_r.row     = row_in;
               next_r.ras_cnt = T_RAS;
            end
            // precharge of an idle bank is accepted and changes nothing
            if (rd || wr) next_r.err_acc = 1'b1;
         end
         dbra_pkg::DBRA_ACTIVE: begin
            // row stays open until a precharge names this bank
            if (pre) begin
               next_r.state  = dbra_pkg::DBRA_PRECHARGING;
               next_r.rp_cnt = T_RP;
            end else if ((rd || wr) && ap) begin
               next_r.state    = dbra_pkg::DBRA_AP_WAIT;
               next_r.lock_cnt = wr ? T_WRA : T_RTP;
            end
            if (act) next_r.err_act = 1'b1;
         end
         dbra_pkg::DBRA_AP_WAIT: begin
            // lockout: hold the precharge until restore and tRAS are both done
            if (r.lock_cnt == 8'h00 && r.ras_cnt == 8'h00) begin
               next_r.state  = dbra_pkg::DBRA_PRECHARGING;
               next_r.rp_cnt = T_RP;
            end
            if (act) next_r.err_act = 1'b1;
         end
         dbra_pkg::DBRA_PRECHARGING: begin
            if (pre) begin
               next_r.rp_cnt = T_RP;
            end else if (r.rp_cnt <= 8'h02) begin
               // idle from the edge tRP after the precharge, not one later
               next_r.state = dbra_pkg::DBRA_IDLE;
            end
            if (act) next_r.err_act = 1'b1;
            if (rd || wr) next_r.err_acc = 1'b1;
         end
      endcase
   end

   // one register for all bank state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r       <= '0;
         r.state <= dbra_pkg::DBRA_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign state    = r.state;
   assign open_row = r.row;
   assign err_act  = r.err_act;
   assign err_acc  = r.err_acc;
endmodule : dbra_bank

`default_nettype wire

// ---- rtl/dbra_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbra_regs.svh"

// Functional notes
// - background neighbour refresh protects adjacent rows
// - capability page reports code 1000, unlimited
// - low nibble holds code, upper bits ignored
// - activate takes group, bank and row
// - row stays open until bank precharged
// - precharge closes one or all; wait tRP
// - repeated precharge accepted, period restarts
// - address bit 10 on access engages auto precharge
// - lockout delays precharge until restore finishes
// - write auto precharge waits for last stored word
module dbra_top #(
   parameter int BANKS       = 16,  // four groups of four banks
   parameter int ACT_CNT_W   = 16   // per-bank activate counter width
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // command pins, sampled on the same clock as the controller drives them
   input  wire logic                   cs_n,
   input  wire logic                   act_n,
   input  wire logic [1:0]             bg,
   input  wire logic [1:0]             ba,
   input  wire logic [17:0]            addr,      // a16..a14 carry ras/cas/we
   // column access toward the array: open row of the addressed bank
   output var  logic                   access_valid,
   output var  logic                   access_write,
   output var  logic [3:0]             access_bank,
   output var  logic [`DBRA_ROW_W-1:0] access_row,
   // targeted refresh of rows next to a heavily activated row
   output var  logic                   targeted_neighbour_refresh_valid,
   output var  logic [3:0]             targeted_neighbour_refresh_bank,
   output var  logic [`DBRA_ROW_W-1:0] targeted_neighbour_refresh_row,
   // axi4-lite slave
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output var  logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output var  logic                   s_axi_wready,
   output var  logic [1:0]             s_axi_bresp,
   output var  logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output var  logic                   s_axi_arready,
   output var  logic [31:0]            s_axi_rdata,
   output var  logic [1:0]             s_axi_rresp,
   output var  logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   localparam logic [7:0] T_RRD_S = 8'(`DBRA_NS2CYC(`DBRA_T_RRD_S_NS));
   localparam logic [7:0] T_RRD_L = 8'(`DBRA_NS2CYC(`DBRA_T_RRD_L_NS));
   localparam logic [7:0] T_FAW   = 8'(`DBRA_NS2CYC(`DBRA_T_FAW_NS));
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   // all module state in one record
   typedef struct packed {
      logic                             aw_have;   // write address held
      logic [7:0]                       aw_addr;
      logic                             w_have;    // write data held
      logic [31:0]                      w_data;
      logic [3:0]                       w_strb;
      logic                             awready;
      logic                             wready;
      logic                             bvalid;
      logic [1:0]                       bresp;
      logic                             arready;
      logic                             rvalid;
      logic [31:0]                      rdata;
      logic [1:0]                       rresp;
      logic [31:0]                      ctrl;      // refresh enable and threshold
      logic [`DBRA_VIO_W-1:0]           vio;       // sticky timing violations
      logic [31:0]                      act_total; // activates seen
      logic [7:0]                       rrd_s;     // any-group spacing countdown
      logic [3:0][7:0]                  rrd_l;     // per-group spacing countdown
      logic [3:0][7:0]                  faw;       // last four activate windows
      logic [BANKS-1:0][ACT_CNT_W-1:0]  act_cnt;   // activates since last refresh
      logic                             acc_valid;
      logic                             acc_write;
      logic [3:0]                       acc_bank;
      logic [`DBRA_ROW_W-1:0]           acc_row;
      logic                             tnr_valid;
      logic [3:0]                       tnr_bank;
      logic [`DBRA_ROW_W-1:0]           tnr_row;
   } dbra_top_t;

   dbra_top_t r;       // registered state
   dbra_top_t next_r;  // next state

   // flat bank index from group and bank
   function automatic logic [3:0] bank_idx(input logic [1:0] g, input logic [1:0] b);
      bank_idx = {g, b};
   endfunction : bank_idx

   // write one register word under byte enables
   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0]  s);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) res[i*8 +: 8] = d[i*8 +: 8];
      end
      apply_strb = res;
   endfunction : apply_strb

   // command decode; ras/cas/we share a16..a14 outside activate
   dbra_pkg::dbra_cmd_t cmd;
   always_comb begin
      cmd = dbra_pkg::DBRA_CMD_NOP;
      if (!cs_n && !act_n) begin
         cmd = dbra_pkg::DBRA_CMD_ACT;
      end else if (!cs_n) begin
         unique case (addr[16:14])
            3'h2:    cmd = dbra_pkg::DBRA_CMD_PRE;
            3'h5:    cmd = dbra_pkg::DBRA_CMD_RD;
            3'h4:    cmd = dbra_pkg::DBRA_CMD_WR;
            default: cmd = dbra_pkg::DBRA_CMD_NOP; // refresh, mode set etc. not handled
         endcase
      end
   end

   logic [3:0] sel;                      // addressed bank
   assign sel = bank_idx(bg, ba);

   // per-bank strobes and tracker outputs
   logic [BANKS-1:0]                    b_act;
   logic [BANKS-1:0]                    b_pre;
   logic [BANKS-1:0]                    b_rd;
   logic [BANKS-1:0]                    b_wr;
   logic [BANKS-1:0]                    b_err_act;
   logic [BANKS-1:0]                    b_err_acc;
   dbra_pkg::dbra_bank_state_t          b_state [BANKS];
   logic [BANKS-1:0][`DBRA_ROW_W-1:0]   b_row;

   for (genvar i = 0; i < BANKS; i++) begin : g_bank
      // a10 high on precharge reaches every bank
      assign b_act[i] = (cmd == dbra_pkg::DBRA_CMD_ACT) && (sel == 4'(i));
      assign b_pre[i] = (cmd == dbra_pkg::DBRA_CMD_PRE) && (addr[10] || sel == 4'(i));
      assign b_rd[i]  = (cmd == dbra_pkg::DBRA_CMD_RD) && (sel == 4'(i));
      assign b_wr[i]  = (cmd == dbra_pkg::DBRA_CMD_WR) && (sel == 4'(i));
      dbra_bank u_bank (
         .aclk     (aclk),
         .aresetn  (aresetn),
         .act      (b_act[i]),
         .pre      (b_pre[i]),
         .rd       (b_rd[i]),
         .wr       (b_wr[i]),
         .ap       (addr[10]),
         .row_in   (addr),
         .state    (b_state[i]),
         .open_row (b_row[i]),
         .err_act  (b_err_act[i]),
         .err_acc  (b_err_acc[i])
      );
   end

   // bank state summary: open rows low half, precharging high half
   logic [31:0] bank_summary;
   always_comb begin
      bank_summary = '0;
      for (int i = 0; i < BANKS; i++) begin
         bank_summary[i]      = (b_state[i] == dbra_pkg::DBRA_ACTIVE) ||
                                (b_state[i] == dbra_pkg::DBRA_AP_WAIT);
         bank_summary[16 + i] = (b_state[i] == dbra_pkg::DBRA_PRECHARGING);
      end
   end

   // main next-state logic: bus slave, spacing monitors, neighbour refresh
   always_comb begin
      logic                   take_aw;
      logic                   take_w;
      logic                   do_wr;
      logic [7:0]             wa;
      logic [`DBRA_VIO_W-1:0] vio_set;
      logic [ACT_CNT_W-1:0]   thr;
      take_aw = s_axi_awvalid && r.awready;
      take_w  = s_axi_wvalid && r.wready;
      do_wr   = 1'b0;
      wa      = '0;
      vio_set = '0;
      thr     = ACT_CNT_W'(r.ctrl[31:`DBRA_CTRL_THR_LSB]);
      next_r  = r;

      // write channels taken in either order, answer once both are in
      if (take_aw) begin
         next_r.aw_have = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (take_w) begin
         next_r.w_have = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) next_r.bvalid = 1'b0;
      if (next_r.aw_have && next_r.w_have && !r.bvalid) begin
         do_wr          = 1'b1;
         wa             = next_r.aw_addr;
         next_r.aw_have = 1'b0;
         next_r.w_have  = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = RESP_OK;
         // capability and bank state are read-only; unmapped answers error
         if (wa != `DBRA_OFF_CTRL && wa != `DBRA_OFF_VIOLATION) next_r.bresp = RESP_ERR;
      end
      // hold off new write beats while one waits for its response
      next_r.awready = !next_r.aw_have && !next_r.bvalid;
      next_r.wready  = !next_r.w_have && !next_r.bvalid;

      // read channel: data one cycle after the address is taken
      if (s_axi_rvalid && s_axi_rready) next_r.rvalid = 1'b0;
      if (s_axi_arvalid && r.arready) begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = RESP_OK;
         unique case (s_axi_araddr)
            `DBRA_OFF_CAPABILITY: next_r.rdata = {24'h0, `DBRA_CAP_RESET};
            `DBRA_OFF_CTRL:       next_r.rdata = r.ctrl;
            `DBRA_OFF_BANK_STATE: next_r.rdata = bank_summary;
            `DBRA_OFF_VIOLATION:  next_r.rdata = 32'(r.vio);
            `DBRA_OFF_ACT_TOTAL:  next_r.rdata = r.act_total;
            default: begin
               next_r.rdata = 32'h0;
               next_r.rresp = RESP_ERR;
            end
         endcase
      end
      next_r.arready = !next_r.rvalid;

      // spacing countdowns
      if (r.rrd_s != 8'h00) next_r.rrd_s = r.rrd_s - 8'h01;
      for (int g = 0; g < 4; g++) begin
         if (r.rrd_l[g] != 8'h00) next_r.rrd_l[g] = r.rrd_l[g] - 8'h01;
         if (r.faw[g] != 8'h00) next_r.faw[g] = r.faw[g] - 8'h01;
      end

      // activate: spacing checks and counters
      next_r.tnr_valid = 1'b0;
      if (cmd == dbra_pkg::DBRA_CMD_ACT) begin
         if (r.rrd_s != 8'h00) vio_set[`DBRA_VIO_RRD_S] = 1'b1;
         if (r.rrd_l[bg] != 8'h00) vio_set[`DBRA_VIO_RRD_L] = 1'b1;
         if (r.faw[3] != 8'h00) vio_set[`DBRA_VIO_FAW] = 1'b1;
         // load one less: an activate exactly T_RRD_S or T_RRD_L later is legal
         next_r.rrd_s     = T_RRD_S - 8'h01;
         next_r.rrd_l[bg] = T_RRD_L - 8'h01;
         next_r.faw       = {r.faw[2:0], T_FAW - 8'h01};
         next_r.act_total = r.act_total + 32'h1;
         // busy counter: neighbours of a hot row get a targeted refresh
         if (r.ctrl[`DBRA_CTRL_TNR_EN_BIT] && r.act_cnt[sel] >= thr - ACT_CNT_W'(1)) begin
            next_r.act_cnt[sel] = '0;
            next_r.tnr_valid    = 1'b1;
            next_r.tnr_bank     = sel;
            next_r.tnr_row      = addr;
         end else begin
            next_r.act_cnt[sel] = r.act_cnt[sel] + ACT_CNT_W'(1);
         end
      end

      // column access presents the row held open in that bank
      next_r.acc_valid = 1'b0;
      if ((cmd == dbra_pkg::DBRA_CMD_RD || cmd == dbra_pkg::DBRA_CMD_WR) &&
          (b_state[sel] == dbra_pkg::DBRA_ACTIVE)) begin
         next_r.acc_valid = 1'b1;
         next_r.acc_write = (cmd == dbra_pkg::DBRA_CMD_WR);
         next_r.acc_bank  = sel;
         next_r.acc_row   = b_row[sel];
      end

      if (|b_err_act) vio_set[`DBRA_VIO_ACT_BUSY] = 1'b1;
      if (|b_err_acc) vio_set[`DBRA_VIO_ACC_IDLE] = 1'b1;

      // register writes; a new violation wins over its clear
      if (do_wr && wa == `DBRA_OFF_CTRL) begin
         next_r.ctrl = apply_strb(r.ctrl, next_r.w_data, next_r.w_strb);
      end
      if (do_wr && wa == `DBRA_OFF_VIOLATION && next_r.w_strb[0]) begin
         next_r.vio = r.vio & ~next_r.w_data[`DBRA_VIO_W-1:0];
      end
      next_r.vio = next_r.vio | vio_set;
   end

   // single state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r      <= '0;
         r.ctrl <= `DBRA_CTRL_RESET;
      end else begin
         r <= next_r;
      end
   end

   // every output straight from the state register
   assign s_axi_awready                    = r.awready;
   assign s_axi_wready                     = r.wready;
   assign s_axi_bvalid                     = r.bvalid;
   assign s_axi_bresp                      = r.bresp;
   assign s_axi_arready                    = r.arready;
   assign s_axi_rvalid                     = r.rvalid;
   assign s_axi_rdata                      = r.rdata;
   assign s_axi_rresp                      = r.rresp;
   assign access_valid                     = r.acc_valid;
   assign access_write                     = r.acc_write;
   assign access_bank                      = r.acc_bank;
   assign access_row                       = r.acc_row;
   assign targeted_neighbour_refresh_valid = r.tnr_valid;
   assign targeted_neighbour_refresh_bank  = r.tnr_bank;
   assign targeted_neighbour_refresh_row   = r.tnr_row;
endmodule : dbra_top

`default_nettype wire

// ---- bench/dbra_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level checks: register read path, capability write refusal and column access decode
module dbra_top_properties (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        cs_n,
   input wire logic        act_n,
   input wire logic [1:0]  bg,
   input wire logic [1:0]  ba,
   input wire logic [17:0] addr,
   input wire logic        access_valid,
   input wire logic        access_write,
   input wire logic [3:0]  access_bank,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a read address handed over
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // a write address to the read-only capability word
   sequence s_aw_cap;
      s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00;
   endsequence
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken while answering");
   a_cap_code: assert property (s_rd_take ##0 s_axi_araddr == 8'h00 |=> s_axi_rdata == 32'h8)
      else $error("capability word wrong");
   a_cap_ro: assert property (s_aw_cap |=> s_axi_bvalid && s_axi_bresp == 2'h2)
      else $error("capability write not refused");
   // column access only follows a read or write command
   a_acc_cause: assert property (access_valid |-> $past(!cs_n && act_n && addr[16:15] == 2'b10))
      else $error("access pulse without command");
   a_acc_bank: assert property (access_valid |-> access_bank == $past({bg, ba}))
      else $error("access bank wrong");
   a_acc_dir: assert property (access_valid |-> access_write == $past(!addr[14]))
      else $error("access direction wrong");
   a_acc_gap: assert property (access_valid && !(!cs_n && act_n) |=> !access_valid)
      else $error("access pulse stretched");
endmodule : dbra_top_properties
`default_nettype wire

// ---- bench/dbra_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// controller stand-in: one command, then deselect for a chosen gap
module dbra_ctrl_model (
   input  wire logic        aclk,
   output var  logic        cs_n,
   output var  logic        act_n,
   output var  logic [1:0]  bg,
   output var  logic [1:0]  ba,
   output var  logic [17:0] addr
);
   initial begin
      cs_n = 1'b1;
      act_n = 1'b1;
      {bg, ba} = 4'h0;
      addr = 18'h0;
   end
   // caller stands just past an edge; a short gap breaks spacing on purpose
   task automatic cmd(input logic act, input logic [3:0] bank, input logic [17:0] a, input int gap);
      cs_n <= 1'b0;
      act_n <= ~act;
      {bg, ba} <= bank;
      addr <= a;
      @(posedge aclk);
      // a zero gap leaves the pins to the next command: no double drive
      if (gap > 0) begin
         cs_n <= 1'b1;
         act_n <= 1'b1;
         addr <= ~a; // deselected pins must not echo the command
         repeat (gap) @(posedge aclk);
      end
   endtask : cmd
endmodule : dbra_ctrl_model
`default_nettype wire

// ---- bench/ddr4_bank_row_activation_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddr4_bank_row_activation_tb;
   logic aclk = 0, aresetn = 0, cs_n, act_n, acc_v, acc_w, tnr_v;
   logic [1:0]  bg, ba, s_axi_bresp, s_axi_rresp;
   logic [3:0]  acc_bank, tnr_bank;
   logic [17:0] addr, acc_row, tnr_row;
   logic [22:0] acc_seen = '0, tnr_seen = '0; // last access and last refresh request
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int   bad_count = 0, check_count = 0;
   always #2.5 aclk = ~aclk;
   dbra_ctrl_model dbra_ctrl_model_i (.aclk, .cs_n, .act_n, .bg, .ba, .addr);
   dbra_top dbra_top_i (.aclk, .aresetn, .cs_n, .act_n, .bg, .ba, .addr,
      .access_valid(acc_v), .access_write(acc_w), .access_bank(acc_bank), .access_row(acc_row),
      .targeted_neighbour_refresh_valid(tnr_v), .targeted_neighbour_refresh_bank(tnr_bank),
      .targeted_neighbour_refresh_row(tnr_row), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // remember the last pulse of each kind for later compares
   always @(posedge aclk) begin
      if (acc_v) acc_seen <= {acc_w, acc_bank, acc_row};
      if (tnr_v) tnr_seen <= {1'b1, tnr_bank, tnr_row};
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         n++;
      end while (!s_axi_bvalid && n < 50);
      if (!s_axi_bvalid) bad_count++; // no answer counts as a mismatch
      s_axi_bready <= 0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         n++;
      end while (!s_axi_rvalid && n < 50);
      if (!s_axi_rvalid) bad_count++; // no answer counts as a mismatch
      s_axi_rready <= 0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : axi_rd
   task summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // a hang is cut off well past the roughly 150 cycles the tests need
   initial begin
      #20000;
      bad_count++;
      summarize;
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      axi_rd(8'h00, 32'h8, 2'h0);
      axi_wr(8'h00, 32'hffff_fff1, 2'h2);
      axi_rd(8'h00, 32'h8, 2'h0);
      axi_rd(8'h04, 32'h0400_0001, 2'h0);
      axi_rd(8'h20, 32'h0, 2'h2);
      dbra_ctrl_model_i.cmd(1, 4'h5, 18'h2abcd, 2);
      dbra_ctrl_model_i.cmd(0, 4'h5, 18'h14000, 2);
      chk(32'(acc_seen), {9'h0, 1'b0, 4'h5, 18'h2abcd});
      dbra_ctrl_model_i.cmd(0, 4'h5, 18'h10400, 2);
      chk(32'(acc_seen), {9'h0, 1'b1, 4'h5, 18'h2abcd});
      axi_rd(8'h08, 32'h20, 2'h0);
      repeat (40) @(posedge aclk);
      axi_rd(8'h08, 32'h0, 2'h0);
      // second activate to a busy bank, then access to an idle bank
      dbra_ctrl_model_i.cmd(1, 4'h0, 18'h00011, 3);
      dbra_ctrl_model_i.cmd(1, 4'h0, 18'h00022, 3);
      dbra_ctrl_model_i.cmd(0, 4'h9, 18'h14000, 3);
      dbra_ctrl_model_i.cmd(0, 4'h0, 18'h14000, 3);
      chk(32'(acc_seen), {14'h0, 18'h00011});
      axi_rd(8'h0c, 32'h3, 2'h0);
      dbra_ctrl_model_i.cmd(0, 4'h0, 18'h08400, 6);
      axi_rd(8'h08, 32'h0, 2'h0);
      axi_wr(8'h0c, 32'h1f, 2'h0);
      axi_rd(8'h0c, 32'h0, 2'h0);
      dbra_ctrl_model_i.cmd(1, 4'h4, 18'h00001, 0);
      dbra_ctrl_model_i.cmd(1, 4'h5, 18'h00002, 4);
      axi_rd(8'h0c, 32'h8, 2'h0);
      dbra_ctrl_model_i.cmd(0, 4'h0, 18'h08400, 6);
      axi_wr(8'h04, 32'h0002_0001, 2'h0);
      repeat (2) begin
         dbra_ctrl_model_i.cmd(1, 4'h3, 18'h00123, 8);
         dbra_ctrl_model_i.cmd(0, 4'h3, 18'h08000, 8);
      end
      chk(32'(tnr_seen), {9'h0, 1'b1, 4'h3, 18'h00123});
      summarize;
   end
endmodule : ddr4_bank_row_activation_tb
bind dbra_top dbra_top_properties dbra_top_properties_i (.aclk, .aresetn, .cs_n, .act_n, .bg,
   .ba, .addr, .access_valid, .access_write, .access_bank, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid);
`default_nettype wire
